// >>> bst_consts.vh
/*
 * constants of the boundary scan test port: controller states, instruction
 * codes, register lengths and reset values.
 * assumes: included by the design, the checker and the bench; definitions only.
 */
`ifndef BST_CONSTS_VH
`define BST_CONSTS_VH

// ----------------------------------------------------------------------
// controller states
// ----------------------------------------------------------------------
`define BST_ST_RESET      4'h0
`define BST_ST_IDLE       4'h1
`define BST_ST_SEL_DR     4'h2
`define BST_ST_CAP_DR     4'h3
`define BST_ST_SHIFT_DR   4'h4
`define BST_ST_EXIT1_DR   4'h5
`define BST_ST_PAUSE_DR   4'h6
`define BST_ST_EXIT2_DR   4'h7
`define BST_ST_UPD_DR     4'h8
`define BST_ST_SEL_IR     4'h9
`define BST_ST_CAP_IR     4'hA
`define BST_ST_SHIFT_IR   4'hB
`define BST_ST_EXIT1_IR   4'hC
`define BST_ST_PAUSE_IR   4'hD
`define BST_ST_EXIT2_IR   4'hE
`define BST_ST_UPD_IR     4'hF

// ----------------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------------
`define BST_IR_LEN        3
`define BST_INS_EXTEST    3'h0
`define BST_INS_IDCODE    3'h1
`define BST_INS_SAMPLE_Z  3'h2
`define BST_INS_SAMPLE    3'h4
`define BST_INS_BYPASS    3'h7
`define BST_IR_CAPTURE    3'h1

// ----------------------------------------------------------------------
// data registers
// ----------------------------------------------------------------------
`define BST_ID_LEN        32
`define BST_ID_CODE       32'h0A5C_3001
`define BST_BSR_LEN       109
`define BST_OE_CELL       108
`define BST_SYNC_IDLE     3'h3

`endif

// >>> bst_tap.v
/*
 * boundary scan test port of a synchronous burst memory: controller,
 * instruction, bypass, identification and boundary scan registers.
 * assumes: test pins are asynchronous to clk_sys and at least four times
 * slower; pad pull-ups on the mode select and serial input are resolved
 * outside; sys_rst doubles as the power-up reset. ring_in passes two flops
 * and should hold still around a data capture; tap_state trails the
 * controller by one clock.
 */
`timescale 1ns/1ns
`include "bst_consts.vh"

module bst_tap (
   input  wire                      clk_sys,
   input  wire                      sys_rst,
   input  wire                      tck_pin,
   input  wire                      tms_pin,
   input  wire                      tdi_pin,
   input  wire [`BST_BSR_LEN-1:0]   ring_in,
   output reg                       tdo_out,
   output reg                       tdo_oe_n,
   output reg  [`BST_BSR_LEN-1:0]   ring_drive,
   output reg                       extest_act,
   output reg                       q_float,
   output reg  [3:0]                tap_state
);

   // ----------------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------------
   reg  [2:0]              sync_a;
   reg  [2:0]              sync_b;
   reg                     tck_last;
   reg  [`BST_BSR_LEN-1:0] ring_a;
   reg  [`BST_BSR_LEN-1:0] ring_b;
   wire                    tck_s;
   wire                    tms_s;
   wire                    tdi_s;
   wire                    tck_rise;
   wire                    tck_fall;

   // pulled-up pins idle high, so mode select and data read one from reset;
   // the test clock idles low, so no false edge follows reset
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         sync_a   <= `BST_SYNC_IDLE;
         sync_b   <= `BST_SYNC_IDLE;
         tck_last <= 1'b0;
      end else begin
         sync_a   <= {tck_pin, tms_pin, tdi_pin};
         sync_b   <= sync_a;
         tck_last <= tck_s;
      end
   end

   always @(posedge clk_sys) begin
      ring_a <= ring_in;
      ring_b <= ring_a;
   end

   assign tck_s    = sync_b[2];
   assign tms_s    = sync_b[1];
   assign tdi_s    = sync_b[0];
   assign tck_rise = tck_s & ~tck_last;
   assign tck_fall = ~tck_s & tck_last;

   // ----------------------------------------------------------------------
   // decode functions
   // ----------------------------------------------------------------------
   function is_ring_ins;
      input [2:0] ins;
      begin
         is_ring_ins = (ins == `BST_INS_EXTEST) || (ins == `BST_INS_SAMPLE)
                    || (ins == `BST_INS_SAMPLE_Z);
      end
   endfunction

   function [3:0] step;
      input [3:0] st;
      input       m;
      begin
         case (st)
            `BST_ST_RESET:    step = m ? `BST_ST_RESET    : `BST_ST_IDLE;
            `BST_ST_IDLE:     step = m ? `BST_ST_SEL_DR   : `BST_ST_IDLE;
            `BST_ST_SEL_DR:   step = m ? `BST_ST_SEL_IR   : `BST_ST_CAP_DR;
            `BST_ST_CAP_DR:   step = m ? `BST_ST_EXIT1_DR : `BST_ST_SHIFT_DR;
            `BST_ST_SHIFT_DR: step = m ? `BST_ST_EXIT1_DR : `BST_ST_SHIFT_DR;
            `BST_ST_EXIT1_DR: step = m ? `BST_ST_UPD_DR   : `BST_ST_PAUSE_DR;
            `BST_ST_PAUSE_DR: step = m ? `BST_ST_EXIT2_DR : `BST_ST_PAUSE_DR;
            `BST_ST_EXIT2_DR: step = m ? `BST_ST_UPD_DR   : `BST_ST_SHIFT_DR;
            `BST_ST_UPD_DR:   step = m ? `BST_ST_SEL_DR   : `BST_ST_IDLE;
            `BST_ST_SEL_IR:   step = m ? `BST_ST_RESET    : `BST_ST_CAP_IR;
            `BST_ST_CAP_IR:   step = m ? `BST_ST_EXIT1_IR : `BST_ST_SHIFT_IR;
            `BST_ST_SHIFT_IR: step = m ? `BST_ST_EXIT1_IR : `BST_ST_SHIFT_IR;
            `BST_ST_EXIT1_IR: step = m ? `BST_ST_UPD_IR   : `BST_ST_PAUSE_IR;
            `BST_ST_PAUSE_IR: step = m ? `BST_ST_EXIT2_IR : `BST_ST_PAUSE_IR;
            `BST_ST_EXIT2_IR: step = m ? `BST_ST_UPD_IR   : `BST_ST_SHIFT_IR;
            `BST_ST_UPD_IR:   step = m ? `BST_ST_SEL_DR   : `BST_ST_IDLE;
            default:          step = `BST_ST_RESET;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------------
   // controller
   // ----------------------------------------------------------------------
   reg  [3:0] state;
   wire [3:0] next_state;

   assign next_state = step(state, tms_s);

   // five rises with mode select high reach the reset state from anywhere
   always @(posedge clk_sys) begin
      if (sys_rst)
         state <= `BST_ST_RESET;
      else if (tck_rise)
         state <= next_state;
   end

   // ----------------------------------------------------------------------
   // instruction register
   // ----------------------------------------------------------------------
   reg  [`BST_IR_LEN-1:0] ir_shift;
   reg  [`BST_IR_LEN-1:0] ir_cur;
   wire                   in_reset;
   wire                   in_cap_dr;
   wire                   in_shift_dr;
   wire                   in_upd_dr;
   wire                   in_cap_ir;
   wire                   in_shift_ir;
   wire                   in_upd_ir;
   wire                   ir_extest;
   wire                   ir_samplez;

   // single-state views of the controller and of the current instruction
   assign in_reset    = (state == `BST_ST_RESET);
   assign in_cap_dr   = (state == `BST_ST_CAP_DR);
   assign in_shift_dr = (state == `BST_ST_SHIFT_DR);
   assign in_upd_dr   = (state == `BST_ST_UPD_DR);
   assign in_cap_ir   = (state == `BST_ST_CAP_IR);
   assign in_shift_ir = (state == `BST_ST_SHIFT_IR);
   assign in_upd_ir   = (state == `BST_ST_UPD_IR);
   assign ir_extest   = (ir_cur == `BST_INS_EXTEST);
   assign ir_samplez  = (ir_cur == `BST_INS_SAMPLE_Z);

   // capture pattern, then serial load with the oldest bit leaving first
   always @(posedge clk_sys) begin
      if (sys_rst)
         ir_shift <= `BST_INS_IDCODE;
      else if (tck_rise && in_cap_ir)
         ir_shift <= `BST_IR_CAPTURE;
      else if (tck_rise && in_shift_ir)
         ir_shift <= {tdi_s, ir_shift[`BST_IR_LEN-1:1]};
   end

   // the reset state forces the identification instruction on every clock,
   // so pin control drops out without waiting for another test clock rise
   always @(posedge clk_sys) begin
      if (sys_rst)
         ir_cur <= `BST_INS_IDCODE;
      else if (in_reset)
         ir_cur <= `BST_INS_IDCODE;
      else if (tck_rise && in_upd_ir)
         ir_cur <= ir_shift;
   end

   // ----------------------------------------------------------------------
   // data registers
   // ----------------------------------------------------------------------
   reg                     bypass_bit;
   reg  [`BST_ID_LEN-1:0]  id_shift;
   reg  [`BST_BSR_LEN-1:0] bsr;
   wire                    sel_ring;
   wire                    sel_id;
   wire                    sel_bypass;

   // reserved codes fall back to the bypass path
   assign sel_ring   = is_ring_ins(ir_cur);
   assign sel_id     = (ir_cur == `BST_INS_IDCODE);
   assign sel_bypass = !sel_ring && !sel_id;

   // bypass is cleared on every data capture, whatever the instruction
   always @(posedge clk_sys) begin
      if (sys_rst)
         bypass_bit <= 1'b0;
      else if (tck_rise && in_cap_dr)
         bypass_bit <= 1'b0;
      else if (tck_rise && in_shift_dr && sel_bypass)
         bypass_bit <= tdi_s;
   end

   // identification code reloads only while it is the selected register
   always @(posedge clk_sys) begin
      if (sys_rst)
         id_shift <= `BST_ID_CODE;
      else if (tck_rise && in_cap_dr && sel_id)
         id_shift <= `BST_ID_CODE;
      else if (tck_rise && in_shift_dr && sel_id)
         id_shift <= {tdi_s, id_shift[`BST_ID_LEN-1:1]};
   end

   // ring capture takes the synchronised copy of the pins
   always @(posedge clk_sys) begin
      if (sys_rst)
         bsr <= {`BST_BSR_LEN{1'b0}};
      else if (tck_rise && in_cap_dr && sel_ring)
         bsr <= ring_b;
      else if (tck_rise && in_shift_dr && sel_ring)
         bsr <= {tdi_s, bsr[`BST_BSR_LEN-1:1]};
   end

   // ----------------------------------------------------------------------
   // update latches and pin control
   // ----------------------------------------------------------------------
   reg  [`BST_BSR_LEN-1:0] next_drive;

   always @* begin
      next_drive = ring_drive;
      if (in_reset)
         next_drive[`BST_OE_CELL] = 1'b1;
      else if (tck_rise && in_upd_dr && sel_ring)
         next_drive = bsr;
   end

   // none of this reaches the memory core; read drivers only see q_float
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         ring_drive <= {{(`BST_BSR_LEN-1){1'b0}}, 1'b1} << `BST_OE_CELL;
         extest_act <= 1'b0;
         q_float    <= 1'b0;
      end else begin
         ring_drive <= next_drive;
         extest_act <= ir_extest;
         q_float    <= ir_samplez
                    || (ir_extest && !ring_drive[`BST_OE_CELL]);
      end
   end

   // ----------------------------------------------------------------------
   // serial output, changed on the falling test clock
   // ----------------------------------------------------------------------
   reg next_tdo;
   reg next_oe_n;

   // the enable follows the state seen at the fall, so it opens one half
   // period into the shift and closes one half period after leaving it
   always @* begin
      next_oe_n = !(in_shift_dr || in_shift_ir);
      if (in_shift_ir)
         next_tdo = ir_shift[0];
      else if (sel_ring)
         next_tdo = bsr[0];
      else if (sel_id)
         next_tdo = id_shift[0];
      else
         next_tdo = bypass_bit;
   end

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         tdo_out  <= 1'b0;
         tdo_oe_n <= 1'b1;
      end else if (tck_fall) begin
         tdo_out  <= next_tdo;
         tdo_oe_n <= next_oe_n;
      end
   end

   // ----------------------------------------------------------------------
   // state report
   // ----------------------------------------------------------------------
   // debug copy of the controller state, one clock behind it
   always @(posedge clk_sys) begin
      if (sys_rst)
         tap_state <= `BST_ST_RESET;
      else
         tap_state <= state;
   end

endmodule // bst_tap

// >>> bst_chk_checker.sv
/*
 * assertions on the scan port outputs against its test pins.
 * assumes: bound to bst_tap; clk_sys oversamples the slow test clock.
 */
`timescale 1ns/1ns
`include "bst_consts.vh"
module bst_chk (
   input wire                    clk_sys,
   input wire                    sys_rst,
   input wire                    tck_pin,
   input wire                    tms_pin,
   input wire                    tdi_pin,
   input wire [`BST_BSR_LEN-1:0] ring_in,
   input wire                    tdo_out,
   input wire                    tdo_oe_n,
   input wire [`BST_BSR_LEN-1:0] ring_drive,
   input wire                    extest_act,
   input wire                    q_float,
   input wire [3:0]              tap_state
);
   // -------------------------------------------------------------------
   // test clock edge ages and mode select run length
   // -------------------------------------------------------------------
   reg       tck_d;
   reg [3:0] rise_age;
   reg [3:0] fall_age;
   reg [2:0] hi_cnt;
   always @(posedge clk_sys) begin
      tck_d <= tck_pin;
      if (sys_rst) begin
         rise_age <= 4'hF;
         fall_age <= 4'hF;
         hi_cnt   <= 3'h0;
      end else begin
         rise_age <= (tck_pin && !tck_d) ? 4'h0 : rise_age + {3'h0, rise_age != 4'hF};
         fall_age <= (!tck_pin && tck_d) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hF};
         if (tck_pin && !tck_d)
            hi_cnt <= tms_pin ? hi_cnt + {2'h0, hi_cnt != 3'h5} : 3'h0;
      end
   end
   // -------------------------------------------------------------------
   // properties
   // -------------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   a_reset_values: assert property (
      $fell(sys_rst) |-> tdo_oe_n && tap_state == `BST_ST_RESET && !extest_act
      && ring_drive == {1'b1, 108'h0}) else $error("bad values after reset");
   a_preset_reset: assert property (
      (tap_state == `BST_ST_RESET)[*4] |-> ring_drive[`BST_OE_CELL] && !extest_act && !q_float)
      else $error("reset state without preset");
   a_state_on_rise: assert property (
      $changed(tap_state) |-> rise_age < 4'h8) else $error("state moved without test clock rise");
   a_tdo_on_fall: assert property (
      $changed(tdo_out) || $changed(tdo_oe_n) |-> fall_age < 4'h8)
      else $error("serial output moved without test clock fall");
   a_tms_reset: assert property (
      tck_pin && !tck_d && tms_pin && hi_cnt >= 3'h4 |-> ##[1:10] tap_state == `BST_ST_RESET)
      else $error("five mode select highs did not reset");
   a_oe_outside: assert property (
      !tdo_oe_n |-> tap_state inside {`BST_ST_SHIFT_DR, `BST_ST_EXIT1_DR,
      `BST_ST_SHIFT_IR, `BST_ST_EXIT1_IR}) else $error("serial output driven outside shift");
   a_oe_in_shift: assert property (
      (tap_state == `BST_ST_SHIFT_DR)[*8] |-> !tdo_oe_n) else $error("serial output floated in shift");
   a_float_extest: assert property (
      extest_act && $past(extest_act) && $stable(ring_drive[`BST_OE_CELL])
      && tap_state != `BST_ST_RESET |-> q_float == !ring_drive[`BST_OE_CELL])
      else $error("read float does not follow cell 108");
endmodule // bst_chk

bind bst_tap bst_chk bst_chk_i (.clk_sys, .sys_rst, .tck_pin, .tms_pin, .tdi_pin, .ring_in,
   .tdo_out, .tdo_oe_n, .ring_drive, .extest_act, .q_float, .tap_state);

// >>> bst_ctl.sv
/*
 * scan controller model: drives test clock, mode select and serial input.
 * assumes: tasks entered at a clk_sys rise; test clock period 8 clk_sys cycles.
 */
`timescale 1ns/1ns
module bst_ctl (
   input  wire clk_sys,
   input  wire tdo_out,
   input  wire tdo_oe_n,
   output reg  tck_pin,
   output reg  tms_pin,
   output reg  tdi_pin
);
   reg last;
   initial begin
      tck_pin = 1'b0;
      tms_pin = 1'b1;
      tdi_pin = 1'b1;
      last    = 1'b0;
   end
   // one test clock period; the released output reads as the inverse of its last value
   task step(input m, input d, output o);
      begin
         tms_pin <= m;
         tdi_pin <= d;
         repeat (4) @(posedge clk_sys);
         tck_pin <= 1'b1;
         repeat (2) @(posedge clk_sys);
         o = tdo_oe_n ? ~last : tdo_out;
         last = o;
         repeat (2) @(posedge clk_sys);
         tck_pin <= 1'b0;
      end
   endtask
   // idle to shift, n bits least significant first, then update and idle
   task shift(input ir, input integer n, input [108:0] din, output [108:0] dout);
      integer i;
      reg     o;
      begin
         dout = 109'h0;
         step(1'b1, 1'b1, o);
         if (ir)
            step(1'b1, 1'b1, o);
         step(1'b0, 1'b1, o);
         step(1'b0, 1'b1, o);
         for (i = 0; i < n; i = i + 1) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
         end
         step(1'b1, 1'b1, o);
         step(1'b0, 1'b1, o);
      end
   endtask
   task reset5;
      integer i;
      reg     o;
      begin
         for (i = 0; i < 5; i = i + 1)
            step(1'b1, 1'b1, o);
         step(1'b0, 1'b1, o);
      end
   endtask
endmodule // bst_ctl

// >>> tb.sv
/*
 * self-checking bench of the scan port with a scan controller model.
 * assumes: bst_tap, bst_ctl and the checker are compiled alongside.
 */
`timescale 1ns/1ns
`include "bst_consts.vh"
module tb;
   localparam [108:0] PA = {1'b1, {27{4'h9}}};
   localparam [108:0] PB = {1'b0, {27{4'h3}}};
   reg                     clk_sys;
   reg                     sys_rst;
   reg  [108:0]            ring_in;
   wire                    tck_pin;
   wire                    tms_pin;
   wire                    tdi_pin;
   wire                    tdo_out;
   wire                    tdo_oe_n;
   wire [108:0]            ring_drive;
   wire                    extest_act;
   wire                    q_float;
   wire [3:0]              tap_state;
   integer                 mismatches;
   integer                 samples_checked;
   integer                 cycles;
   reg  [108:0]            got;

   bst_tap bst_tap_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .tck_pin(tck_pin),
      .tms_pin(tms_pin), .tdi_pin(tdi_pin), .ring_in(ring_in), .tdo_out(tdo_out),
      .tdo_oe_n(tdo_oe_n), .ring_drive(ring_drive), .extest_act(extest_act),
      .q_float(q_float), .tap_state(tap_state));
   bst_ctl bst_ctl_i (.clk_sys(clk_sys), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n),
      .tck_pin(tck_pin), .tms_pin(tms_pin), .tdi_pin(tdi_pin));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // -------------------------------------------------------------------
   // compare and close
   // -------------------------------------------------------------------
   task check(input [8*10:1] what, input [108:0] seen, input [108:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task conclude;
      begin
         $display("checked %0d mismatches %0d", samples_checked, mismatches);
         if (mismatches == 0 && samples_checked > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   always @(posedge clk_sys) begin
      cycles = cycles + 1;
      if (cycles == 30000) begin
         mismatches = mismatches + 1;
         conclude;
      end
   end
   // -------------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------------
   task t_power;
      begin
         check("oe_n", tdo_oe_n, 1'b1);
         check("state", tap_state, `BST_ST_RESET);
         check("drive", ring_drive, {1'b1, 108'h0});
         check("float", q_float, 1'b0);
         bst_ctl_i.reset5;
         bst_ctl_i.shift(1'b0, 32, 109'h0, got);
         check("idcode", got[31:0], `BST_ID_CODE);
         $display("test power done");
      end
   endtask
   task t_bypass;
      begin
         bst_ctl_i.shift(1'b1, 3, `BST_INS_BYPASS, got);
         check("ir_cap", got[2:0], `BST_IR_CAPTURE);
         bst_ctl_i.shift(1'b0, 4, 109'hB, got);
         check("bypass", got[3:0], 4'h6);
         $display("test bypass done");
      end
   endtask
   task t_ring;
      integer   k;
      reg [2:0] code;
      begin
         for (k = 0; k < 3; k = k + 1) begin
            code = (k == 0) ? `BST_INS_SAMPLE_Z : (k == 1) ? `BST_INS_SAMPLE : `BST_INS_EXTEST;
            ring_in <= PA >> k;
            bst_ctl_i.shift(1'b1, 3, code, got);
            check("ir_cap", got[2:0], `BST_IR_CAPTURE);
            bst_ctl_i.shift(1'b0, 109, PB, got);
            check("capture", got, PA >> k);
            check("preload", ring_drive, PB);
            check("extest", extest_act, code == `BST_INS_EXTEST);
            check("float", q_float, k != 1);
         end
         bst_ctl_i.reset5;
         check("keep", ring_drive, {1'b1, PB[107:0]});
         check("ext_off", extest_act, 1'b0);
         check("float_off", q_float, 1'b0);
         bst_ctl_i.shift(1'b0, 32, 109'h0, got);
         check("idcode", got[31:0], `BST_ID_CODE);
         $display("test ring done");
      end
   endtask

   initial begin
      mismatches = 0;
      samples_checked = 0;
      cycles = 0;
      sys_rst = 1'b1;
      ring_in = 109'h0;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      t_power;
      t_bypass;
      t_ring;
      conclude;
   end
endmodule // tb
